// file: rtl/pei_pkg.sv
package pei_pkg;
    // Management register addresses
    localparam logic [4:0] PEI_ADDR_MCTL = 5'h11;
    localparam logic [4:0] PEI_ADDR_EVT = 5'h12;
    localparam logic [4:0] PEI_ADDR_FCC = 5'h14;
    localparam logic [4:0] PEI_ADDR_REC = 5'h15;
    // Widths
    localparam int PEI_AW = 5;
    localparam int PEI_DW = 16;
    localparam int PEI_NSRC = 7;
    localparam int PEI_CW = 8;
    // Event register field positions
    localparam int PEI_PEND_LSB = 8;
    localparam int PEI_EN_LSB = 0;
    // Source index inside the seven-bit vectors
    localparam int PEI_SRC_ED = 6;
    localparam int PEI_SRC_LINK = 5;
    localparam int PEI_SRC_SPD = 4;
    localparam int PEI_SRC_DUP = 3;
    localparam int PEI_SRC_ANC = 2;
    localparam int PEI_SRC_FHF = 1;
    localparam int PEI_SRC_RHF = 0;
    // Master control bit positions
    localparam int PEI_MC_OE = 0;
    localparam int PEI_MC_EN = 1;
    localparam int PEI_MC_TEST = 2;
    localparam int PEI_MC_W = 3;
    // Reset values and counter limits
    localparam logic [PEI_NSRC-1:0] PEI_SRC_RST = 7'h00;
    localparam logic [PEI_MC_W-1:0] PEI_MC_RST = 3'h0;
    localparam logic [PEI_CW-1:0] PEI_CNT_RST = 8'h00;
    localparam logic [PEI_CW-1:0] PEI_CNT_MAX = 8'hFF;
    localparam logic [PEI_CW-1:0] PEI_CNT_ONE = 8'h01;
    localparam logic [PEI_DW-1:0] PEI_RD_RST = 16'h0000;
    localparam int PEI_HALF_BIT = 7;
    // Receive carrier tracker states
    typedef enum logic [3:0] {
        PEI_RX_IDLE = 4'b0001,
        PEI_RX_GOOD = 4'b0010,
        PEI_RX_ERR = 4'b0100,
        PEI_RX_COL = 4'b1000
    } pei_rx_type;
endpackage

// file: rtl/pei_event_irq.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] Event status latches regardless of its enable
// [R2] Interrupt needs source enable and master controls
// [R3] Pending bits clear on the returning read
// [R4] Pending bits 14..8 in fixed source order
// [R5] Enable bits 6..0, reset zero, same order
// [R6] Bits 15 and 7 ignore writes, read zero
// [R7] False-carrier count counts, clears on read
// [R8] False-carrier count sticks at maximum
// [R9] Rx error count: carrier with bad symbol
// [R10] At most one count per carrier event
// [R11] No count when collision during carrier
// [R12] Rx error count sticks at maximum
// [R13] False-carrier half-full sets its pending bit
// [R14] Rx error half-full sets its pending bit
// [R15] Master enable gates all event interrupts
// [R16] Output enable makes shared pin interrupt output
// [R17] Test bit forces interrupt while set
// [R18] Half-full means counter top bit set
// [R19] Interrupt holds until enabled pending bits cleared
module pei_event_irq (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Management register port
    input wire logic [pei_pkg::PEI_AW-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [pei_pkg::PEI_DW-1:0] i_reg_wdata,
    output logic [pei_pkg::PEI_DW-1:0] o_reg_rdata,
    // Status change pulses from the transceiver core
    input wire logic i_energy_detect_evt,
    input wire logic i_link_change_evt,
    input wire logic i_speed_change_evt,
    input wire logic i_duplex_change_evt,
    input wire logic i_autoneg_done_evt,
    // Receive path indications
    input wire logic i_false_carrier_evt,
    input wire logic i_rx_carrier,
    input wire logic i_rx_invalid_symbol,
    input wire logic i_rx_collision,
    // Shared power-down / interrupt pin
    input wire logic i_powerdown_or_irq_pin,
    output logic o_powerdown_or_irq_pin_n,
    output logic o_powerdown_or_irq_pin_oe,
    // Internal results
    output logic o_irq,
    output logic o_powerdown_req
);
    import pei_pkg::*;

    // Address match, shared by read and write decode
    function automatic logic hit(input logic [PEI_AW-1:0] a, input logic [PEI_AW-1:0] t);
        hit = (a == t);
    endfunction

    logic [PEI_NSRC-1:0] pend_ff; // Latched event status
    logic [PEI_NSRC-1:0] ien_ff; // Per-source enables
    logic [PEI_MC_W-1:0] mc_ff; // Master control bits
    logic [PEI_CW-1:0] fc_ff; // False carrier tally
    logic [PEI_CW-1:0] re_ff; // Rx symbol error tally
    logic [PEI_CW-1:0] nxt_fc;
    logic [PEI_CW-1:0] nxt_re;
    pei_rx_type rx_ff; // Carrier event tracker
    pei_rx_type nxt_rx;
    logic [PEI_NSRC-1:0] src_evt; // All sources this cycle
    logic re_inc; // One rx error count due
    logic fc_clr; // Read of false carrier tally
    logic re_clr; // Read of rx error tally
    logic evt_clr; // Read of event register
    logic fc_half_rise;
    logic re_half_rise;
    logic [PEI_NSRC-1:0] nxt_pend; // Pending bits after this edge
    logic nxt_irq;
    logic pin_s1_ff; // Pin synchroniser, first stage
    logic pin_s2_ff; // Pin synchroniser, second stage
    logic irq_ff;

    // Read strobes that clear state as a side effect
    assign evt_clr = i_reg_rd && hit(i_reg_addr, PEI_ADDR_EVT);
    assign fc_clr = i_reg_rd && hit(i_reg_addr, PEI_ADDR_FCC);
    assign re_clr = i_reg_rd && hit(i_reg_addr, PEI_ADDR_REC);

    // Half-full crossing: top bit goes from clear to set
    assign fc_half_rise = nxt_fc[PEI_HALF_BIT] && !fc_ff[PEI_HALF_BIT]; // [R18]
    assign re_half_rise = nxt_re[PEI_HALF_BIT] && !re_ff[PEI_HALF_BIT]; // [R18]

    // Gather event sources in register order
    always_comb begin
        src_evt = PEI_SRC_RST;
        src_evt[PEI_SRC_ED] = i_energy_detect_evt; // [R4]
        src_evt[PEI_SRC_LINK] = i_link_change_evt;
        src_evt[PEI_SRC_SPD] = i_speed_change_evt;
        src_evt[PEI_SRC_DUP] = i_duplex_change_evt;
        src_evt[PEI_SRC_ANC] = i_autoneg_done_evt;
        src_evt[PEI_SRC_FHF] = fc_half_rise; // [R13]
        src_evt[PEI_SRC_RHF] = re_half_rise; // [R14]
    end

    // Next pending bits: a new event wins over the clearing read
    always_comb begin
        nxt_pend = (evt_clr ? PEI_SRC_RST : pend_ff) | src_evt; // [R1] [R3]
    end

    // Pending bits register
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pend_ff <= PEI_SRC_RST;
        end else begin
            pend_ff <= nxt_pend; // [R1]
        end
    end

    // Software-written enables and master controls
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ien_ff <= PEI_SRC_RST;
            mc_ff <= PEI_MC_RST;
        end else if (i_reg_wr) begin
            // Only low seven bits store; 15 and 7 are dropped
            if (hit(i_reg_addr, PEI_ADDR_EVT)) begin
                ien_ff <= i_reg_wdata[PEI_EN_LSB +: PEI_NSRC]; // [R5] [R6]
            end
            if (hit(i_reg_addr, PEI_ADDR_MCTL)) begin
                mc_ff <= i_reg_wdata[PEI_MC_W-1:0];
            end
        end
    end

    // False carrier tally: count, stick at max, clear on read
    always_comb begin
        nxt_fc = fc_ff;
        if (fc_clr) begin
            // An event in the read cycle starts the new count
            nxt_fc = i_false_carrier_evt ? PEI_CNT_ONE : PEI_CNT_RST; // [R7]
        end else if (i_false_carrier_evt && fc_ff != PEI_CNT_MAX) begin
            nxt_fc = fc_ff + PEI_CNT_ONE; // [R7] [R8]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            fc_ff <= PEI_CNT_RST;
        end else begin
            fc_ff <= nxt_fc;
        end
    end

    // Carrier tracker: remembers error or collision inside one carrier
    always_comb begin
        nxt_rx = rx_ff;
        re_inc = 1'b0;
        case (rx_ff)
            PEI_RX_IDLE: begin
                if (i_rx_carrier) begin
                    nxt_rx = i_rx_collision ? PEI_RX_COL :
                             (i_rx_invalid_symbol ? PEI_RX_ERR : PEI_RX_GOOD);
                end
            end
            PEI_RX_GOOD: begin
                if (!i_rx_carrier) begin
                    nxt_rx = PEI_RX_IDLE;
                end else if (i_rx_collision) begin
                    nxt_rx = PEI_RX_COL; // [R11]
                end else if (i_rx_invalid_symbol) begin
                    nxt_rx = PEI_RX_ERR; // [R9]
                end
            end
            PEI_RX_ERR: begin
                // Further bad symbols do not count again
                if (!i_rx_carrier) begin
                    nxt_rx = PEI_RX_IDLE;
                    re_inc = 1'b1; // [R9] [R10]
                end else if (i_rx_collision) begin
                    nxt_rx = PEI_RX_COL; // [R11]
                end
            end
            PEI_RX_COL: begin
                // Collided carrier never counts
                if (!i_rx_carrier) begin
                    nxt_rx = PEI_RX_IDLE; // [R11]
                end
            end
            default: begin
                nxt_rx = PEI_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_ff <= PEI_RX_IDLE;
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    // Rx error tally: count once per bad carrier, stick at max
    always_comb begin
        nxt_re = re_ff;
        if (re_clr) begin
            nxt_re = re_inc ? PEI_CNT_ONE : PEI_CNT_RST; // [R9]
        end else if (re_inc && re_ff != PEI_CNT_MAX) begin
            nxt_re = re_ff + PEI_CNT_ONE; // [R12]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            re_ff <= PEI_CNT_RST;
        end else begin
            re_ff <= nxt_re;
        end
    end

    // Read data register, captured before the clear takes effect
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= PEI_RD_RST;
        end else if (i_reg_rd) begin
            o_reg_rdata <= PEI_RD_RST;
            if (hit(i_reg_addr, PEI_ADDR_EVT)) begin
                // Bits 15 and 7 stay zero
                o_reg_rdata[PEI_PEND_LSB +: PEI_NSRC] <= pend_ff; // [R3] [R4] [R6]
                o_reg_rdata[PEI_EN_LSB +: PEI_NSRC] <= ien_ff; // [R5]
            end
            if (hit(i_reg_addr, PEI_ADDR_MCTL)) begin
                o_reg_rdata[PEI_MC_W-1:0] <= mc_ff;
            end
            if (hit(i_reg_addr, PEI_ADDR_FCC)) begin
                o_reg_rdata[PEI_CW-1:0] <= fc_ff; // [R7]
            end
            if (hit(i_reg_addr, PEI_ADDR_REC)) begin
                o_reg_rdata[PEI_CW-1:0] <= re_ff; // [R9]
            end
        end
    end

    // Interrupt level from the next pending state
    // Operands are named directly so the level follows every pending change
    assign nxt_irq = mc_ff[PEI_MC_TEST] ||
                     (mc_ff[PEI_MC_EN] && |(nxt_pend & ien_ff)); // [R2] [R15] [R17] [R19]

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_ff <= 1'b0;
            o_powerdown_or_irq_pin_n <= 1'b1;
            o_powerdown_or_irq_pin_oe <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
            o_powerdown_or_irq_pin_n <= !nxt_irq; // Active low on the pin
            o_powerdown_or_irq_pin_oe <= mc_ff[PEI_MC_OE]; // [R16]
        end
    end
    assign o_irq = irq_ff;

    // Pin synchroniser and power-down request when pin is an input
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
            o_powerdown_req <= 1'b0;
        end else begin
            pin_s1_ff <= i_powerdown_or_irq_pin;
            pin_s2_ff <= pin_s1_ff;
            o_powerdown_req <= !mc_ff[PEI_MC_OE] && !pin_s2_ff; // [R16]
        end
    end

    // Checks
    a_pend_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R1]
        |src_evt |=> ((pend_ff & $past(src_evt)) == $past(src_evt)))
        else $error("event not latched");
    a_read_clears: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R3]
        (evt_clr && src_evt == PEI_SRC_RST) |=> (pend_ff == PEI_SRC_RST))
        else $error("pending not cleared by read");
    a_resv_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R6]
        $past(evt_clr) |-> (o_reg_rdata[PEI_DW-1] == 1'b0 && o_reg_rdata[PEI_PEND_LSB-1] == 1'b0))
        else $error("reserved bit reads one");
    a_master_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R15]
        (!mc_ff[PEI_MC_EN] && !mc_ff[PEI_MC_TEST]) |=> !o_irq)
        else $error("interrupt without master enable");
    a_test_force: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R17]
        mc_ff[PEI_MC_TEST] [*2] |=> o_irq)
        else $error("test interrupt not forced");
    a_fc_stick: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R8]
        (fc_ff == PEI_CNT_MAX && !fc_clr) |=> (fc_ff == PEI_CNT_MAX))
        else $error("false carrier tally wrapped");
    a_fc_count: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R7]
        (i_false_carrier_evt && !fc_clr && fc_ff != PEI_CNT_MAX) |=> (fc_ff == $past(fc_ff) + PEI_CNT_ONE))
        else $error("false carrier tally missed");
    a_re_once: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R10]
        (!re_clr && i_rx_carrier) |=> (re_ff == $past(re_ff)))
        else $error("rx error counted inside carrier");
    a_re_collide: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R11]
        (rx_ff == PEI_RX_COL && !re_clr) |=> (re_ff == $past(re_ff)))
        else $error("rx error counted with collision");
    a_half_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R13]
        (fc_ff == (PEI_CNT_MAX >> 1) && i_false_carrier_evt && !fc_clr) |=> pend_ff[PEI_SRC_FHF])
        else $error("half-full not flagged");
    a_irq_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rstn) // [R19]
        (mc_ff[PEI_MC_EN] && |(pend_ff & ien_ff) && !evt_clr) |=> o_irq)
        else $error("interrupt dropped while pending");

    c_irq_seen: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !o_irq ##1 o_irq);
    c_re_counted: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        re_inc);
    c_fc_sat: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
        fc_ff == PEI_CNT_MAX);
endmodule
`default_nettype wire

// file: dv/pei_mgmt_model.sv
`timescale 1ns/10ps
`default_nettype none
// Station management controller: one-cycle read and write strobes
module pei_mgmt_model (
    // Clock
    input wire logic i_clk_sys,
    // Register port toward the block
    output logic [pei_pkg::PEI_AW-1:0] o_reg_addr,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [pei_pkg::PEI_DW-1:0] o_reg_wdata,
    input wire logic [pei_pkg::PEI_DW-1:0] i_reg_rdata
);
    import pei_pkg::*;
    // Idle values at time zero
    initial begin
        o_reg_addr = 5'h00;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 16'h0000;
    end
    // Write: strobe spans one rising edge, then address and data are scrambled
    task automatic wr(input logic [PEI_AW-1:0] a, input logic [PEI_DW-1:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        o_reg_wr = 1'b0;
        o_reg_addr = ~a;
        o_reg_wdata = ~d;
    endtask
    // Read: data is registered at the edge that takes the strobe
    task automatic rd(input logic [PEI_AW-1:0] a, output logic [PEI_DW-1:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        o_reg_rd = 1'b0;
        o_reg_addr = ~a;
        d = i_reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pei_pkg::*;
    // Clock, reset and event stimulus
    logic i_clk_sys, i_rstn, fc_evt, carrier, bad_sym, coll, pd_drv;
    logic [4:0] evt;
    // Register port and outputs
    logic [PEI_AW-1:0] addr;
    logic wr, rd, pin_n, oe, irq, pd_req;
    logic [PEI_DW-1:0] wdata, rdata, rv;
    wire pin_w = oe ? pin_n : pd_drv;
    int error_cnt = 0;
    int n_tests = 0;
    pei_mgmt_model pei_mgmt_model_i (.i_clk_sys(i_clk_sys), .o_reg_addr(addr), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_wdata(wdata), .i_reg_rdata(rdata));
    pei_event_irq pei_event_irq_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_energy_detect_evt(evt[4]), .i_link_change_evt(evt[3]), .i_speed_change_evt(evt[2]),
        .i_duplex_change_evt(evt[1]), .i_autoneg_done_evt(evt[0]), .i_false_carrier_evt(fc_evt),
        .i_rx_carrier(carrier), .i_rx_invalid_symbol(bad_sym), .i_rx_collision(coll),
        .i_powerdown_or_irq_pin(pin_w), .o_powerdown_or_irq_pin_n(pin_n),
        .o_powerdown_or_irq_pin_oe(oe), .o_irq(irq), .o_powerdown_req(pd_req));
    // Free-running system clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Compare one value
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Read a register and compare
    task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] exp);
        pei_mgmt_model_i.rd(a, rv);
        chk(what, rv, exp);
    endtask
    // Run of back-to-back false carrier pulses
    task automatic fc(input int n);
        @(negedge i_clk_sys);
        fc_evt = 1'b1;
        repeat (n) @(negedge i_clk_sys);
        fc_evt = 1'b0;
    endtask
    // Carrier events with a number of bad symbols and optional collision
    task automatic frame(input int nbad, input logic col, input int n);
        repeat (n) begin
            @(negedge i_clk_sys);
            carrier = 1'b1;
            for (int k = 0; k < 4; k++) begin
                bad_sym = (k < nbad);
                coll = col;
                @(negedge i_clk_sys);
            end
            carrier = 1'b0;
            bad_sym = 1'b0;
            coll = 1'b0;
            @(negedge i_clk_sys);
        end
    endtask
    // Reset values and unmapped read
    task automatic t_reset();
        rchk("event reg", PEI_ADDR_EVT, 16'h0000);
        rchk("false carrier", PEI_ADDR_FCC, 16'h0000);
        rchk("rx error", PEI_ADDR_REC, 16'h0000);
        rchk("master ctl", PEI_ADDR_MCTL, 16'h0000);
        rchk("unmapped", 5'h13, 16'h0000);
        pei_mgmt_model_i.wr(PEI_ADDR_EVT, 16'hFFFF);
        rchk("enables all", PEI_ADDR_EVT, 16'h007F);
        pei_mgmt_model_i.wr(PEI_ADDR_EVT, 16'h0000);
        rchk("enables none", PEI_ADDR_EVT, 16'h0000);
        $display("test reset done");
    endtask
    // Each of the five status-change sources latches with its enable off and clears on read
    task automatic t_status();
        for (int i = 0; i < 5; i++) begin
            @(negedge i_clk_sys);
            evt = 5'h10 >> i;
            @(negedge i_clk_sys);
            evt = 5'h00;
            rchk("pending bit", PEI_ADDR_EVT, 16'h4000 >> i);
            rchk("pending cleared", PEI_ADDR_EVT, 16'h0000);
        end
        $display("test status done");
    endtask
    // Interrupt gating, pin drive and test bit
    task automatic t_irq();
        pei_mgmt_model_i.wr(PEI_ADDR_EVT, 16'h0020);
        @(negedge i_clk_sys);
        evt = 5'h08;
        @(negedge i_clk_sys);
        evt = 5'h00;
        chk("irq master off", {15'h0, irq}, 16'h0000);
        pei_mgmt_model_i.wr(PEI_ADDR_MCTL, 16'h0002);
        // The level follows the control bits one edge after the write
        @(negedge i_clk_sys);
        chk("irq master on", {15'h0, irq}, 16'h0001);
        pei_mgmt_model_i.wr(PEI_ADDR_MCTL, 16'h0003);
        @(negedge i_clk_sys);
        chk("pin drive", {14'h0, oe, pin_n}, 16'h0002);
        rchk("link pending", PEI_ADDR_EVT, 16'h2020);
        chk("irq after read", {15'h0, irq}, 16'h0000);
        pei_mgmt_model_i.wr(PEI_ADDR_MCTL, 16'h0004);
        @(negedge i_clk_sys);
        chk("test irq", {15'h0, irq}, 16'h0001);
        pd_drv = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        chk("power down", {14'h0, oe, pd_req}, 16'h0001);
        pd_drv = 1'b1;
        pei_mgmt_model_i.wr(PEI_ADDR_MCTL, 16'h0000);
        pei_mgmt_model_i.wr(PEI_ADDR_EVT, 16'h0000);
        $display("test irq done");
    endtask
    // False carrier count, half-full and saturation
    task automatic t_fcc();
        fc(3);
        rchk("fc count", PEI_ADDR_FCC, 16'h0003);
        rchk("fc cleared", PEI_ADDR_FCC, 16'h0000);
        fc(127);
        rchk("fc below half", PEI_ADDR_EVT, 16'h0000);
        fc(1);
        rchk("fc half", PEI_ADDR_EVT, 16'h0200);
        fc(200);
        rchk("fc max", PEI_ADDR_FCC, 16'h00FF);
        $display("test false carrier done");
    endtask
    // Receive error count per carrier event
    task automatic t_rec();
        frame(3, 1'b0, 1);
        rchk("rx once", PEI_ADDR_REC, 16'h0001);
        frame(1, 1'b1, 1);
        rchk("rx collision", PEI_ADDR_REC, 16'h0000);
        frame(0, 1'b0, 1);
        rchk("rx clean", PEI_ADDR_REC, 16'h0000);
        frame(1, 1'b0, 127);
        rchk("rx below half", PEI_ADDR_EVT, 16'h0000);
        frame(1, 1'b0, 1);
        rchk("rx half", PEI_ADDR_EVT, 16'h0100);
        frame(2, 1'b0, 140);
        rchk("rx max", PEI_ADDR_REC, 16'h00FF);
        $display("test rx error done");
    endtask
    // Watchdog
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end
    // Main sequence
    initial begin
        i_rstn = 1'b0;
        evt = 5'h00;
        fc_evt = 1'b0;
        carrier = 1'b0;
        bad_sym = 1'b0;
        coll = 1'b0;
        pd_drv = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        i_rstn = 1'b1;
        t_reset();
        t_status();
        t_irq();
        t_fcc();
        t_rec();
        finish_test();
    end
endmodule
`default_nettype wire
